// ===== src/fah_defines.vh
`ifndef FAH_DEFINES_VH
`define FAH_DEFINES_VH

// =====================================================================
// Address and data layout
`define FAH_ADDR_W 24
`define FAH_DATA_W 16
`define FAH_LOW_LANE_MSB 7
`define FAH_HIGH_LANE_LSB 8
// Top word-address bit per density: 32, 64, 128 Mbit
`define FAH_TOP_BIT_32M 21
`define FAH_TOP_BIT_64M 22
`define FAH_TOP_BIT_128M 23
`define FAH_DENS_32M 2'h0
`define FAH_DENS_64M 2'h1
`define FAH_DENS_128M 2'h2

// =====================================================================
// Chip enable levels that select and deselect the device (host drives these patterns)
`define FAH_CE_SELECT 3'h0
`define FAH_CE_IDLE 3'h7

// =====================================================================
// Strobe timing in ns and derived cycles at 100 MHz
`define FAH_CLK_NS 10
`define FAH_SETUP_NS 70
`define FAH_STROBE_NS 70
`define FAH_HOLD_NS 20
`define FAH_READ_NS 80
`define FAH_RESET_LOW_NS 100
`define FAH_WAKE_NS 200
`define FAH_SETUP_CYC ((`FAH_SETUP_NS + `FAH_CLK_NS - 1) / `FAH_CLK_NS)
`define FAH_STROBE_CYC ((`FAH_STROBE_NS + `FAH_CLK_NS - 1) / `FAH_CLK_NS)
`define FAH_HOLD_CYC ((`FAH_HOLD_NS + `FAH_CLK_NS - 1) / `FAH_CLK_NS)
`define FAH_READ_CYC ((`FAH_READ_NS + `FAH_CLK_NS - 1) / `FAH_CLK_NS)
`define FAH_RESET_LOW_CYC ((`FAH_RESET_LOW_NS + `FAH_CLK_NS - 1) / `FAH_CLK_NS)
`define FAH_WAKE_CYC ((`FAH_WAKE_NS + `FAH_CLK_NS - 1) / `FAH_CLK_NS)
`define FAH_CNT_W 8

`endif

// ===== src/fah_activity_mon.v
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Activity indicator monitor: level mode busy, pulse mode completion
module fah_activity_mon
(
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Indicator pin and mode
	input wire activityIndicator,
	input wire pulseMode,
	// Results
	output reg deviceBusy,
	output reg doneEvent
);

	reg indPrev_reg;

	// Level mode: low means busy; pulse mode: a low pulse starts on completion
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			indPrev_reg <= 1'b1;
			deviceBusy <= 1'b0;
			doneEvent <= 1'b0;
		end
		else
		begin
			indPrev_reg <= activityIndicator;
			deviceBusy <= pulseMode ? 1'b0 : ~activityIndicator;
			// Level mode done is busy-to-ready; pulse mode done is the pulse's start
			doneEvent <= pulseMode ? (indPrev_reg & ~activityIndicator) : (~indPrev_reg & activityIndicator);
		end
	end

endmodule // fah_activity_mon

`default_nettype wire

// ===== src/fah_flash_host.v
// Operation
// - Word address spans bits 21, 22 or 23 down to 1 by density.
// - Low lane carries commands and write data, returns array, query, id or status.
// - Address and data are captured on write strobe rising edge; hold them around it.
// - Device drives data only while output enable is low during a read.
`timescale 1ns/1ps
`default_nettype none
`include "fah_defines.vh"

module fah_flash_host
(
	// Clock and reset
	input wire clk,
	input wire rstn,
	// User request side
	input wire reqValid,
	input wire reqWrite,
	input wire [`FAH_ADDR_W-1:0] reqAddr,
	input wire [`FAH_DATA_W-1:0] reqWdata,
	input wire reqPowerDown,
	input wire byteMode,
	input wire pulseMode,
	input wire [1:0] density,
	output reg reqReady,
	output reg rspValid,
	output reg [`FAH_DATA_W-1:0] rspRdata,
	output reg busy,
	output reg opDone,
	// Flash pins
	output reg [`FAH_ADDR_W-1:0] flashAddr,
	output reg byteSelectAddr,
	output reg [2:0] chipEnable,
	output reg outEnableN,
	output reg writeStrobeN,
	output reg widthSelectN,
	output reg resetPowerdownN,
	output reg [`FAH_DATA_W-1:0] dqOut,
	output reg dqLowOe,
	output reg dqHighOe,
	input wire [`FAH_DATA_W-1:0] dqIn,
	input wire activityIndicator
);

	// =====================================================================
	// States
	localparam [2:0] ST_RESET = 3'h0;
	localparam [2:0] ST_WAKE = 3'h1;
	localparam [2:0] ST_IDLE = 3'h2;
	localparam [2:0] ST_SETUP = 3'h3;
	localparam [2:0] ST_STROBE = 3'h4;
	localparam [2:0] ST_HOLD = 3'h5;
	localparam [2:0] ST_DOWN = 3'h6;

	// Counts are worked out as integers, then cut to the counter width on purpose
	localparam integer SETUP_INT = `FAH_SETUP_CYC;
	localparam integer STROBE_INT = `FAH_STROBE_CYC;
	localparam integer HOLD_INT = `FAH_HOLD_CYC;
	localparam integer READ_INT = `FAH_READ_CYC;
	localparam integer RESET_LOW_INT = `FAH_RESET_LOW_CYC;
	localparam integer WAKE_INT = `FAH_WAKE_CYC;
	localparam [`FAH_CNT_W-1:0] SETUP_CYC = SETUP_INT[`FAH_CNT_W-1:0];
	localparam [`FAH_CNT_W-1:0] STROBE_CYC = STROBE_INT[`FAH_CNT_W-1:0];
	localparam [`FAH_CNT_W-1:0] HOLD_CYC = HOLD_INT[`FAH_CNT_W-1:0];
	localparam [`FAH_CNT_W-1:0] READ_CYC = READ_INT[`FAH_CNT_W-1:0];
	localparam [`FAH_CNT_W-1:0] RESET_LOW_CYC = RESET_LOW_INT[`FAH_CNT_W-1:0];
	localparam [`FAH_CNT_W-1:0] WAKE_CYC = WAKE_INT[`FAH_CNT_W-1:0];

	// Mask to the decoded word-address span; unused upper pins stay low
	function [`FAH_ADDR_W-1:0] spanMask;
		input [1:0] dens;
		begin
			case (dens)
				`FAH_DENS_32M: spanMask = {{(`FAH_ADDR_W-1-`FAH_TOP_BIT_32M){1'b0}}, {`FAH_TOP_BIT_32M{1'b1}}, 1'b0};
				`FAH_DENS_64M: spanMask = {{(`FAH_ADDR_W-1-`FAH_TOP_BIT_64M){1'b0}}, {`FAH_TOP_BIT_64M{1'b1}}, 1'b0};
				default: spanMask = {{`FAH_TOP_BIT_128M{1'b1}}, 1'b0};
			endcase
		end
	endfunction

	reg [2:0] state_reg;
	reg [`FAH_CNT_W-1:0] count_reg;
	reg write_reg;
	reg byte_reg;
	reg addr0_reg;
	wire monBusy;
	wire monDone;

	// =====================================================================
	// Indicator watcher
	fah_activity_mon uMon
	(
		.clk(clk),
		.rstn(rstn),
		.activityIndicator(activityIndicator),
		.pulseMode(pulseMode),
		.deviceBusy(monBusy),
		.doneEvent(monDone)
	);

	// Indicator results straight to registered outputs
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			busy <= 1'b0;
			opDone <= 1'b0;
		end
		else
		begin
			busy <= monBusy;
			opDone <= monDone;
		end
	end

	// =====================================================================
	// Cycle sequencer: one access at a time, fixed setup, strobe, hold
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= ST_RESET;
			count_reg <= RESET_LOW_CYC;
			write_reg <= 1'b0;
			byte_reg <= 1'b0;
			addr0_reg <= 1'b0;
			reqReady <= 1'b0;
			rspValid <= 1'b0;
			rspRdata <= 16'h0000;
			flashAddr <= 24'h00_0000;
			byteSelectAddr <= 1'b0;
			chipEnable <= `FAH_CE_IDLE;
			outEnableN <= 1'b1;
			writeStrobeN <= 1'b1;
			widthSelectN <= 1'b1;
			resetPowerdownN <= 1'b0;
			dqOut <= 16'h0000;
			dqLowOe <= 1'b0;
			dqHighOe <= 1'b0;
		end
		else
		begin
			rspValid <= 1'b0;
			case (state_reg)
				// Hold the part in reset long enough to clear its sequencer
				ST_RESET:
				begin
					resetPowerdownN <= 1'b0;
					if (count_reg <= 8'h01)
					begin
						state_reg <= ST_WAKE;
						count_reg <= WAKE_CYC;
						resetPowerdownN <= 1'b1;
					end
					else
						count_reg <= count_reg - 8'h01;
				end
				// Writes are not recognised until the wake time has passed
				ST_WAKE:
				begin
					if (count_reg <= 8'h01)
					begin
						state_reg <= ST_IDLE;
						reqReady <= 1'b1;
					end
					else
						count_reg <= count_reg - 8'h01;
				end
				ST_IDLE:
				begin
					widthSelectN <= ~byteMode;
					if (reqPowerDown)
					begin
						state_reg <= ST_DOWN;
						reqReady <= 1'b0;
						resetPowerdownN <= 1'b0;
					end
					else if (reqValid)
					begin
						reqReady <= 1'b0;
						write_reg <= reqWrite;
						byte_reg <= byteMode;
						addr0_reg <= reqAddr[0];
						flashAddr <= reqAddr & spanMask(density);
						byteSelectAddr <= byteMode ? reqAddr[0] : 1'b0;
						chipEnable <= `FAH_CE_SELECT;
						dqOut <= reqWdata;
						// Only drive the high lane for word writes, never in byte mode
						dqLowOe <= reqWrite;
						dqHighOe <= reqWrite & ~byteMode;
						state_reg <= ST_SETUP;
						count_reg <= SETUP_CYC;
					end
				end
				// Address and data settle before the strobe falls
				ST_SETUP:
				begin
					if (count_reg <= 8'h01)
					begin
						state_reg <= ST_STROBE;
						count_reg <= write_reg ? STROBE_CYC : READ_CYC;
						if (write_reg)
							writeStrobeN <= 1'b0;
						else
							outEnableN <= 1'b0;
					end
					else
						count_reg <= count_reg - 8'h01;
				end
				ST_STROBE:
				begin
					if (count_reg <= 8'h01)
					begin
						state_reg <= ST_HOLD;
						count_reg <= HOLD_CYC;
						writeStrobeN <= 1'b1;
						outEnableN <= 1'b1;
						if (!write_reg)
						begin
							rspValid <= 1'b1;
							// Byte reads land on the low lane; high lane is undefined there
							rspRdata <= byte_reg ? {8'h00, dqIn[`FAH_LOW_LANE_MSB:0]} : dqIn;
						end
					end
					else
						count_reg <= count_reg - 8'h01;
				end
				// Keep address and data stable after the rising strobe
				ST_HOLD:
				begin
					if (count_reg <= 8'h01)
					begin
						state_reg <= ST_IDLE;
						chipEnable <= `FAH_CE_IDLE;
						dqLowOe <= 1'b0;
						dqHighOe <= 1'b0;
						reqReady <= 1'b1;
					end
					else
						count_reg <= count_reg - 8'h01;
				end
				// Power-down lasts while requested, then wake time again
				ST_DOWN:
				begin
					if (!reqPowerDown)
					begin
						resetPowerdownN <= 1'b1;
						state_reg <= ST_WAKE;
						count_reg <= WAKE_CYC;
					end
				end
				default:
				begin
					state_reg <= ST_RESET;
					count_reg <= RESET_LOW_CYC;
				end
			endcase
		end
	end

endmodule // fah_flash_host

`default_nettype wire

// ===== tb/fah_host_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "fah_defines.vh"
// ==========================================
// Pin protocol checks beside the host
module fah_host_chk
(
	// Clock, reset and modes
	input wire logic clk,
	input wire logic rstn,
	input wire logic pulseMode,
	input wire logic [1:0] density,
	// Host results
	input wire logic rspValid,
	input wire logic busy,
	input wire logic opDone,
	// Flash pins
	input wire logic [`FAH_ADDR_W-1:0] flashAddr,
	input wire logic byteSelectAddr,
	input wire logic [2:0] chipEnable,
	input wire logic outEnableN,
	input wire logic writeStrobeN,
	input wire logic widthSelectN,
	input wire logic resetPowerdownN,
	input wire logic [`FAH_DATA_W-1:0] dqOut,
	input wire logic dqLowOe,
	input wire logic dqHighOe,
	input wire logic activityIndicator
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_strobe_len: assert property ($fell(writeStrobeN) |-> !writeStrobeN [*7] ##1 writeStrobeN)
		else $error("write strobe width wrong");
	a_write_hold: assert property ($rose(writeStrobeN) |-> $stable(flashAddr) && dqLowOe ##1 $stable(dqOut))
		else $error("address or data moved at strobe end");
	a_we_select: assert property (!writeStrobeN |-> chipEnable == 3'h0 && resetPowerdownN && outEnableN)
		else $error("write strobe outside a selected write");
	a_no_fight: assert property (!outEnableN |-> !dqLowOe && !dqHighOe)
		else $error("host drives data during a read");
	a_byte_lane: assert property (!widthSelectN |-> !dqHighOe)
		else $error("high lane driven in byte mode");
	a_word_sel: assert property (widthSelectN && chipEnable == 3'h0 |-> !byteSelectAddr && !flashAddr[0])
		else $error("byte select used in word mode");
	a_addr_span: assert property (chipEnable == 3'h0 |-> (density != 2'h0 || flashAddr[23:22] == 2'h0)
		&& (density != 2'h1 || !flashAddr[23]))
		else $error("address beyond density");
	a_read_rsp: assert property ($fell(outEnableN) |-> ##8 rspValid)
		else $error("read answer late");
	a_pd_quiet: assert property (!resetPowerdownN |-> writeStrobeN && outEnableN)
		else $error("strobes during power-down");
	a_level_busy: assert property ((!pulseMode && !activityIndicator) [*3] |-> busy)
		else $error("busy missed");
	a_pulse_quiet: assert property (pulseMode [*3] |-> !busy)
		else $error("busy in pulse mode");
	a_done_once: assert property (opDone |=> !opDone)
		else $error("done longer than one cycle");
endmodule // fah_host_chk
`default_nettype wire

// ===== tb/fah_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Flash device seen at its pins
module fah_flash_model
#(
	parameter int BUSY_NS = 400
)
(
	// Pins from the host
	input wire logic [23:0] flashAddr,
	input wire logic byteSelectAddr,
	input wire logic [2:0] chipEnable,
	input wire logic outEnableN,
	input wire logic writeStrobeN,
	input wire logic widthSelectN,
	input wire logic resetPowerdownN,
	input wire logic pulseMode,
	input wire logic [15:0] dqBus,
	// Pins back to the host
	output logic [15:0] devData,
	output logic devLowOe,
	output logic devHighOe,
	output logic stsPullLow
);
	logic [15:0] mem [0:15];
	logic selected;
	logic [3:0] wordIdx;
	event progStart;
	int busyT;
	// Only all-low enables select; power-down deselects
	assign selected = (chipEnable === 3'h0) && resetPowerdownN;
	assign wordIdx = flashAddr[4:1];
	// Drive only in a selected read; array mode is the only read mode here
	assign devLowOe = selected && !outEnableN && writeStrobeN;
	assign devHighOe = devLowOe && widthSelectN;
	assign devData = widthSelectN ? mem[wordIdx] : {8'h00, mem[wordIdx][byteSelectAddr*8 +: 8]};
	// Capture on the strobe's rising edge
	always @(posedge writeStrobeN)
		if (selected)
		begin
			if (widthSelectN)
				mem[wordIdx] = dqBus;
			else
				mem[wordIdx][byteSelectAddr*8 +: 8] = dqBus[7:0];
			->progStart;
		end
	// One sequencer run at a time: level mode holds the line low, pulse mode pulses at the end
	// Pin changes sit 1 ns off the clock edge so the host never races them
	// Power-down resets the sequencer and frees the line at once
	initial
	begin
		stsPullLow = 0;
		forever
		begin
			@(progStart);
			#1;
			stsPullLow = !pulseMode;
			for (busyT = 0; busyT < BUSY_NS && resetPowerdownN; busyT++)
				#1;
			stsPullLow = pulseMode && resetPowerdownN;
			#(50);
			stsPullLow = 0;
		end
	end
endmodule // fah_flash_model
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fah_defines.vh"
`define CHK(a, b) check(a, b)
bind fah_flash_host fah_host_chk chk_u (.clk, .rstn, .pulseMode, .density, .rspValid, .busy, .opDone, .flashAddr,
	.byteSelectAddr, .chipEnable, .outEnableN, .writeStrobeN, .widthSelectN, .resetPowerdownN, .dqOut, .dqLowOe,
	.dqHighOe, .activityIndicator);
// ==========================================
// Bench for the flash host controller
module tb_top;
	logic clk = 0, rstn = 0, reqValid = 0, reqWrite = 0, reqPowerDown = 0, byteMode = 0, pulseMode = 0;
	logic [1:0] density = 2'h2;
	logic [23:0] reqAddr = 0, lastAddr;
	logic [15:0] reqWdata = 0, lastRead;
	int errors = 0, checks_done = 0, cycles = 0;
	wire logic reqReady, rspValid, busy, opDone, byteSelectAddr, outEnableN, writeStrobeN, widthSelectN;
	wire logic resetPowerdownN, dqLowOe, dqHighOe, activityIndicator, devLowOe, devHighOe, stsPullLow;
	wire logic [23:0] flashAddr;
	wire logic [2:0] chipEnable;
	wire logic [15:0] rspRdata, dqOut, dqIn, devData;
	fah_flash_host dut_u (.clk, .rstn, .reqValid, .reqWrite, .reqAddr, .reqWdata, .reqPowerDown, .byteMode,
		.pulseMode, .density, .reqReady, .rspValid, .rspRdata, .busy, .opDone, .flashAddr, .byteSelectAddr,
		.chipEnable, .outEnableN, .writeStrobeN, .widthSelectN, .resetPowerdownN, .dqOut, .dqLowOe, .dqHighOe,
		.dqIn, .activityIndicator);
	fah_flash_model dev_u (.flashAddr, .byteSelectAddr, .chipEnable, .outEnableN, .writeStrobeN, .widthSelectN,
		.resetPowerdownN, .pulseMode, .dqBus(dqIn), .devData, .devLowOe, .devHighOe, .stsPullLow);
	// Shared pins: undriven lanes show a changing pattern, the indicator is pulled up
	assign dqIn[7:0] = dqLowOe ? dqOut[7:0] : devLowOe ? devData[7:0] : ~dqOut[7:0];
	assign dqIn[15:8] = dqHighOe ? dqOut[15:8] : devHighOe ? devData[15:8] : ~dqOut[15:8];
	assign activityIndicator = !stsPullLow;
	always #5 clk = ~clk;
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One request held until taken; a read waits for its answer
	task automatic access(input logic wr, input logic [23:0] addr, input logic [15:0] data);
		int n;
		for (n = 0; n < 300 && reqReady !== 1'b1; n++) @(negedge clk);
		reqWrite = wr;
		reqAddr = addr;
		reqWdata = data;
		reqValid = 1;
		@(negedge clk);
		reqValid = 0;
		lastAddr = flashAddr;
		for (n = 0; n < 40 && !wr && rspValid !== 1'b1; n++) @(negedge clk);
		lastRead = rspRdata;
	endtask
	task automatic word_rw();
		int n;
		access(1, 24'h00_0006, 16'hA5C3);
		repeat (20) @(negedge clk);
		`CHK(busy, 1'b1);
		access(0, 24'h00_0007, 16'h0000);
		`CHK(lastRead, 16'hA5C3);
		for (n = 0; n < 100 && opDone !== 1'b1; n++) @(negedge clk);
		`CHK(opDone, 1'b1);
		repeat (3) @(negedge clk);
		`CHK(busy, 1'b0);
	endtask
	// Byte writes to both halves, byte reads of each, then a word read of the whole word
	task automatic byte_rw();
		byteMode = 1;
		access(1, 24'h00_0009, 16'h005A);
		access(1, 24'h00_0008, 16'h0033);
		access(0, 24'h00_0009, 16'h0000);
		`CHK(lastRead, 16'h005A);
		access(0, 24'h00_0008, 16'h0000);
		`CHK(lastRead, 16'h0033);
		byteMode = 0;
		repeat (20) @(negedge clk);
		access(0, 24'h00_0008, 16'h0000);
		`CHK(lastRead, 16'h5A33);
	endtask
	// Densities rise so a held address never exceeds the new span
	task automatic density_sweep();
		logic [23:0] mask [4] = '{24'h3F_FFFE, 24'h7F_FFFE, 24'hFF_FFFE, 24'hFF_FFFE};
		access(1, 24'h00_001E, 16'h1234);
		for (int d = 0; d < 4; d++)
		begin
			density = d[1:0];
			access(0, 24'hFF_FFFF, 16'h0000);
			`CHK(lastAddr, mask[d]);
			`CHK(lastRead, 16'h1234);
		end
	endtask
	task automatic pulse_done();
		int n;
		pulseMode = 1;
		access(1, 24'h00_0004, 16'hBEEF);
		for (n = 0; n < 100 && opDone !== 1'b1; n++) @(negedge clk);
		`CHK(opDone, 1'b1);
		`CHK(busy, 1'b0);
		repeat (10) @(negedge clk);
		pulseMode = 0;
	endtask
	// Power-down in mid-program frees the indicator; data survives
	task automatic power_cycle();
		int n;
		access(1, 24'h00_0002, 16'h0F0F);
		for (n = 0; n < 300 && reqReady !== 1'b1; n++) @(negedge clk);
		reqPowerDown = 1;
		repeat (6) @(negedge clk);
		`CHK(resetPowerdownN, 1'b0);
		`CHK(busy, 1'b0);
		reqPowerDown = 0;
		access(0, 24'h00_0002, 16'h0000);
		`CHK(lastRead, 16'h0F0F);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// The sequence needs under 2000 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			final_report();
		end
	end
	initial
	begin
		repeat (20) @(negedge clk);
		rstn = 1;
		word_rw();
		byte_rw();
		density_sweep();
		pulse_done();
		power_cycle();
		final_report();
	end
endmodule // tb_top
`default_nettype wire
